// >>> can_mailbox.sv
// mailbox control of one CAN channel: registers, transmit and receive sequencing
// Function
// RL1: thirty-two mailboxes, 0 to 31, each usable for sending or receiving.
// RL2: up to three channels 0 to 2; each instance is one channel.
// RL3: per-mailbox kind code: 0 ordinary mailbox, 1 queued mailbox.
// RL4: transmit queue holds four messages; full flag; fifth push refused.
// RL5: mailbox holds identifier, length code and data bytes 0 to 7.
// RL6: per-mailbox choice of standard or extended identifier.
// RL7: per-mailbox choice of data frame or remote request.
// RL8: software waits for earlier send to finish before rewriting mailbox.
// RL9: software masks mailbox interrupt while loading, unmasks after unless polling.
// RL10: software checks queue not full before loading queued mailbox.
// RL11: send request transmits retained contents; contents remain for resending.
// RL12: software waits for mailbox idle before requesting send, with timeout.
// RL13: clearing send request or queue enable cancels an unsent transmission.
// RL14: cancel fails if frame already started; abort flag shows success.
// RL15: status shows sent frames and overwritten or lost messages.
// RL16: receive mailbox stores each frame with equal identifier.
// RL17: software waits, masks interrupt, then writes receive identifier and type.
// RL18: halt mode stays attached to the bus but stops communicating.
// RL19: on success clear send request and set sticky sent flag.
`timescale 1ns/1ps
`default_nettype none
module can_mailbox #(
  parameter int CHANNEL = 0 // [RL2]
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [can_mbx_pkg::AW-1:0] addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output wire logic [31:0]                rd_data,
  output wire logic                       irq,
  output wire logic                       tx_req,
  output wire logic [28:0]                tx_id,
  output wire logic                       tx_ide,
  output wire logic                       tx_rtr,
  output wire logic [3:0]                 tx_dlc,
  output wire logic [63:0]                tx_data,
  input  wire logic                       tx_start,
  input  wire logic                       tx_done,
  input  wire logic                       rx_valid,
  input  wire logic [28:0]                rx_id,
  input  wire logic                       rx_ide,
  input  wire logic                       rx_rtr,
  input  wire logic [3:0]                 rx_dlc,
  input  wire logic [63:0]                rx_data
);
  import can_mbx_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                    halt;
    logic                    qen;
    logic [IRQ_W-1:0]        istat;
    logic [IRQ_W-1:0]        imask;
    logic [NUM_MB-1:0]       sent;
    logic [NUM_MB-1:0]       lost;
    logic [NUM_MB-1:0]       rxnew;
    logic [NUM_MB-1:0]       kind;
    logic [NUM_MB-1:0]       sreq;
    logic [NUM_MB-1:0]       rxen;
    logic [NUM_MB-1:0][30:0] key;
    tx_st_e                  txs;
    logic [MBW-1:0]          tsel;
    logic                    tfromq;
    logic [QCW-1:0]          tcnt;
    logic                    tpend;
    logic [1:0]              tpw;
    logic                    treq;
    logic [28:0]             tid;
    logic                    tide;
    logic                    trtr;
    logic [3:0]              tdlc;
    logic [63:0]             tdata;
    rx_st_e                  rxs;
    logic [MBW-1:0]          rtgt;
    logic [1:0]              rcnt;
    logic [30:0]             rkey;
    logic [3:0]              rdlc;
    logic [63:0]             rdata;
    logic                    rdmem;
    logic [31:0]             rq;
    logic                    irq;
  } st_s;
  st_s st_r, st_nxt;

  mbx_mem_if mi ();
  mbx_mem u_mem (
    .mclk (mclk),
    .m    (mi)
  );

  logic                 qpush, qpop, qflush, qfull, qempty;
  logic [MBW-1:0]       qhead;
  logic [QCW-1:0]       qcnt;
  tx_queue u_q (
    .mclk     (mclk),
    .rst      (rst),
    .push     (qpush),
    .push_idx (wdata[MBW-1:0]),
    .pop      (qpop),
    .flush    (qflush),
    .head     (qhead),
    .full     (qfull),
    .empty    (qempty),
    .count    (qcnt)
  );

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic in_win(input logic [AW-1:0] a);
    return (a >= A_WIN) && (a <= A_WEND);
  endfunction
  function automatic logic [MEM_AW-1:0] win_idx(input logic [AW-1:0] a);
    logic [AW-1:0] d;
    d = a - A_WIN;
    return d[MEM_AW+1:2];
  endfunction
  // lowest-numbered hit wins; returns {found, index}
  function automatic logic [MBW:0] first_hit(input logic [NUM_MB-1:0] v);
    logic [MBW:0] r;
    r = '0;
    for (int i = NUM_MB - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, MBW'(i)};
      end
    end
    return r;
  endfunction

  logic [NUM_MB-1:0] rx_hits, tx_cands;
  logic [MBW:0]      rx_pick, tx_pick;
  logic              host_mrd, host_mwr, cancel;
  logic [30:0]       fkey;
  assign fkey = {rx_ide, rx_rtr, rx_id};
  for (genvar g = 0; g < NUM_MB; g++) begin : g_mb
    assign rx_hits[g]  = st_r.rxen[g] && (st_r.kind[g] == MB_KIND_NORMAL) && (st_r.key[g] == fkey); // [RL16] [RL6] [RL7]
    assign tx_cands[g] = st_r.sreq[g] && (st_r.kind[g] == MB_KIND_NORMAL); // [RL1]
  end
  assign rx_pick  = first_hit(rx_hits);
  assign tx_pick  = first_hit(tx_cands);
  assign host_mrd = rd_en && in_win(addr);
  assign host_mwr = wr_en && in_win(addr);
  assign qpush    = wr_en && (addr == A_QPUSH) && (st_r.kind[wdata[MBW-1:0]] == MB_KIND_FIFO) && !qfull; // [RL3] [RL4]
  assign qflush   = wr_en && (addr == A_CTRL) && !wdata[CTRL_QEN_BIT] && st_r.qen; // [RL13]
  assign qpop     = (st_r.txs == TX_SENDING) && tx_done && st_r.tfromq;
  assign cancel   = ((st_r.txs == TX_FETCH) || ((st_r.txs == TX_OFFER) && !tx_start)) &&
                    (st_r.tfromq ? !st_r.qen : !st_r.sreq[st_r.tsel]); // [RL13] [RL14]

  // ****************************************
  // memory port sharing: host first, the transmit fetch and the receive store wait
  // ****************************************
  always_comb begin
    mi.we    = host_mwr || (st_r.rxs == RX_STORE);
    mi.waddr = host_mwr ? win_idx(addr) : {st_r.rtgt, st_r.rcnt};
    case (st_r.rcnt)
      W_ID:    mi.wdata = {1'b0, st_r.rkey};
      W_DLO:   mi.wdata = st_r.rdata[31:0];
      W_DHI:   mi.wdata = st_r.rdata[63:32];
      default: mi.wdata = {28'h0, st_r.rdlc};
    endcase
    if (host_mwr) begin
      mi.wdata = wdata;
    end
    mi.raddr = host_mrd ? win_idx(addr) : {st_r.tsel, st_r.tcnt[1:0]};
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // host writes
    if (wr_en) begin
      case (addr)
        A_CTRL: begin
          st_nxt.halt = wdata[CTRL_HALT_BIT];
          st_nxt.qen  = wdata[CTRL_QEN_BIT];
        end
        A_ISTAT: st_nxt.istat = st_r.istat & ~wdata[IRQ_W-1:0];
        A_IMASK: st_nxt.imask = wdata[IRQ_W-1:0];
        A_SENT:  st_nxt.sent  = st_r.sent & ~wdata;
        A_LOST:  st_nxt.lost  = st_r.lost & ~wdata;
        A_RXNEW: st_nxt.rxnew = st_r.rxnew & ~wdata;
        A_KIND:  st_nxt.kind  = wdata;
        A_RXEN:  st_nxt.rxen  = wdata;
        default: ;
      endcase
    end
    if (host_mwr && (win_idx(addr) % 4 == 0)) begin
      st_nxt.key[win_idx(addr) >> 2] = wdata[30:0]; // [RL5] [RL6] [RL7]
    end
    // transmit sequencing
    case (st_r.txs)
      TX_IDLE: begin
        st_nxt.tcnt  = '0;
        st_nxt.tpend = 1'b0;
        if (!st_r.halt) begin // [RL18]
          if (st_r.qen && !qempty) begin
            st_nxt.txs    = TX_FETCH;
            st_nxt.tsel   = qhead;
            st_nxt.tfromq = 1'b1;
          end else if (tx_pick[MBW]) begin
            st_nxt.txs    = TX_FETCH; // [RL11]
            st_nxt.tsel   = tx_pick[MBW-1:0];
            st_nxt.tfromq = 1'b0;
          end
        end
      end
      TX_FETCH: begin
        st_nxt.tpend = !host_mrd && (st_r.tcnt != FETCH_WORDS);
        st_nxt.tpw   = st_r.tcnt[1:0];
        if (st_nxt.tpend) begin
          st_nxt.tcnt = st_r.tcnt + 3'h1;
        end
        if (st_r.tpend) begin
          case (st_r.tpw)
            W_ID: begin
              st_nxt.tide = mi.rdata[IDE_BIT];
              st_nxt.trtr = mi.rdata[RTR_BIT];
              st_nxt.tid  = mi.rdata[IDE_BIT] ? mi.rdata[28:0] : {18'h0, mi.rdata[10:0]}; // [RL6]
            end
            W_DLO:   st_nxt.tdata[31:0]  = mi.rdata;
            W_DHI:   st_nxt.tdata[63:32] = mi.rdata;
            default: begin
              st_nxt.tdlc = mi.rdata[3:0];
              st_nxt.txs  = TX_OFFER;
              st_nxt.treq = 1'b1;
            end
          endcase
        end
      end
      TX_OFFER: begin
        if (tx_start) begin
          st_nxt.txs = TX_SENDING; // [RL14]
        end
      end
      TX_SENDING: begin
        if (tx_done) begin
          st_nxt.txs  = TX_IDLE;
          st_nxt.treq = 1'b0;
          if (!st_r.tfromq && !(wr_en && (addr == A_SREQ))) begin
            st_nxt.sreq[st_r.tsel] = 1'b0; // [RL19]
          end
        end
      end
      default: st_nxt.txs = TX_IDLE;
    endcase
    if (cancel) begin
      st_nxt.txs  = TX_IDLE; // [RL13]
      st_nxt.treq = 1'b0;
    end
    // a fresh request written in the completion cycle is kept
    if (wr_en && (addr == A_SREQ)) begin
      st_nxt.sreq = wdata;
    end
    // receive sequencing
    case (st_r.rxs)
      RX_IDLE: begin
        st_nxt.rcnt = '0;
        if (rx_valid && !st_r.halt && rx_pick[MBW]) begin // [RL18] [RL16]
          st_nxt.rxs   = RX_STORE;
          st_nxt.rtgt  = rx_pick[MBW-1:0];
          st_nxt.rkey  = fkey;
          st_nxt.rdlc  = rx_dlc;
          st_nxt.rdata = rx_data;
          if (st_r.rxnew[rx_pick[MBW-1:0]]) begin
            st_nxt.lost[rx_pick[MBW-1:0]] = 1'b1; // [RL15]
            st_nxt.istat[IRQ_LOST] = 1'b1;
          end
        end
      end
      RX_STORE: begin
        // one holding stage only: a frame landing mid-store is dropped
        if (rx_valid && !st_r.halt) begin
          st_nxt.istat[IRQ_LOST] = 1'b1; // [RL15]
        end
        if (!host_mwr) begin
          st_nxt.rcnt = st_r.rcnt + 2'h1;
          if (st_r.rcnt == W_DLC) begin
            st_nxt.rxs = RX_IDLE;
            st_nxt.rxnew[st_r.rtgt] = 1'b1; // [RL16]
            st_nxt.istat[IRQ_RX] = 1'b1;
          end
        end
      end
      default: st_nxt.rxs = RX_IDLE;
    endcase
    // hardware sets win over software clears
    if ((st_r.txs == TX_SENDING) && tx_done) begin
      st_nxt.sent[st_r.tsel] = 1'b1; // [RL19] [RL15]
      st_nxt.istat[IRQ_SENT] = 1'b1;
    end
    if (cancel) begin
      st_nxt.istat[IRQ_ABORT] = 1'b1; // [RL14]
    end
    // register read, answer in the next cycle
    st_nxt.rdmem = host_mrd;
    st_nxt.rq    = '0;
    if (rd_en) begin
      case (addr)
        A_CTRL:  st_nxt.rq = {30'h0, st_r.qen, st_r.halt};
        A_STAT:  st_nxt.rq = {21'h0, st_r.rxs == RX_STORE, st_r.txs != TX_IDLE, st_r.halt,
                              3'h0, qcnt, qempty, qfull}; // [RL4]
        A_ISTAT: st_nxt.rq = {28'h0, st_r.istat};
        A_IMASK: st_nxt.rq = {28'h0, st_r.imask};
        A_SENT:  st_nxt.rq = st_r.sent;
        A_LOST:  st_nxt.rq = st_r.lost;
        A_RXNEW: st_nxt.rq = st_r.rxnew;
        A_KIND:  st_nxt.rq = st_r.kind;
        A_SREQ:  st_nxt.rq = st_r.sreq;
        A_RXEN:  st_nxt.rq = st_r.rxen;
        default: st_nxt.rq = '0;
      endcase
    end
    st_nxt.irq = |(st_r.istat & st_r.imask);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.halt <= CTRL_RST[CTRL_HALT_BIT];
      st_r.txs  <= TX_IDLE;
      st_r.rxs  <= RX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // memory data already come from a register; only a select sits after it
  assign rd_data = st_r.rdmem ? mi.rdata : st_r.rq;
  assign irq     = st_r.irq;
  assign tx_req  = st_r.treq;
  assign tx_id   = st_r.tid;
  assign tx_ide  = st_r.tide;
  assign tx_rtr  = st_r.trtr;
  assign tx_dlc  = st_r.tdlc;
  assign tx_data = st_r.tdata;

  // ****************************************
  // assertions
  // ****************************************
  property p_qfull;
    @(posedge mclk) disable iff (rst) (qfull && wr_en && (addr == A_QPUSH) && !qpop) |=> (qcnt == 3'h4);
  endproperty
  a_qfull: assert property (p_qfull) else $error("queue grew past four"); // [RL4]
  property p_qkind;
    @(posedge mclk) disable iff (rst) qpush |-> (st_r.kind[wdata[MBW-1:0]] == MB_KIND_FIFO);
  endproperty
  a_qkind: assert property (p_qkind) else $error("ordinary mailbox queued"); // [RL3]
  property p_sent;
    @(posedge mclk) disable iff (rst) ((st_r.txs == TX_SENDING) && tx_done) |=> (st_r.sent[$past(st_r.tsel)] && !tx_req);
  endproperty
  a_sent: assert property (p_sent) else $error("sent flag missing"); // [RL19]
  property p_sreq_clr;
    @(posedge mclk) disable iff (rst)
      ((st_r.txs == TX_SENDING) && tx_done && !st_r.tfromq && !(wr_en && (addr == A_SREQ))) |=> !st_r.sreq[$past(st_r.tsel)];
  endproperty
  a_sreq_clr: assert property (p_sreq_clr) else $error("send request not cleared"); // [RL19]
  property p_cancel;
    @(posedge mclk) disable iff (rst) cancel |=> (!tx_req && st_r.istat[IRQ_ABORT] && (st_r.txs == TX_IDLE));
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel not taken"); // [RL13]
  property p_started;
    @(posedge mclk) disable iff (rst) (st_r.txs == TX_SENDING) |-> !cancel;
  endproperty
  a_started: assert property (p_started) else $error("started frame cancelled"); // [RL14]
  property p_halt;
    @(posedge mclk) disable iff (rst) (st_r.halt && (st_r.txs == TX_IDLE) && (st_r.rxs == RX_IDLE)) |=>
      ((st_r.txs == TX_IDLE) && (st_r.rxs == RX_IDLE));
  endproperty
  a_halt: assert property (p_halt) else $error("activity in halt mode"); // [RL18]
  property p_std_id;
    @(posedge mclk) disable iff (rst) (tx_req && !tx_ide) |-> (tx_id[28:11] == 18'h0);
  endproperty
  a_std_id: assert property (p_std_id) else $error("standard id too wide"); // [RL6]
  property p_offer;
    @(posedge mclk) disable iff (rst) $rose(tx_req) |-> ($past(st_r.txs) == TX_FETCH) && $past(st_r.tpend);
  endproperty
  a_offer: assert property (p_offer) else $error("offer without fetch"); // [RL11]
  property p_rx_done;
    @(posedge mclk) disable iff (rst) ((st_r.rxs == RX_STORE) && (st_r.rcnt == W_DLC) && !host_mwr) |=>
      (st_r.rxnew[$past(st_r.rtgt)] && st_r.istat[IRQ_RX]);
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("stored frame not flagged"); // [RL16]
  property p_lost;
    @(posedge mclk) disable iff (rst) ((st_r.rxs == RX_IDLE) && rx_valid && !st_r.halt && rx_pick[MBW] &&
      st_r.rxnew[rx_pick[MBW-1:0]]) |=> st_r.lost[$past(rx_pick[MBW-1:0])];
  endproperty
  a_lost: assert property (p_lost) else $error("overwrite not flagged"); // [RL15]
  property p_irq;
    @(posedge mclk) disable iff (rst) 1'b1 |=> (irq == $past(|(st_r.istat & st_r.imask)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong"); // [RL9]
  c_sent:  cover property (@(posedge mclk) disable iff (rst) (st_r.txs == TX_SENDING) && tx_done);
  c_abort: cover property (@(posedge mclk) disable iff (rst) cancel);
  c_rx:    cover property (@(posedge mclk) disable iff (rst) (st_r.rxs == RX_STORE) ##1 (st_r.rxs == RX_IDLE));
  c_full:  cover property (@(posedge mclk) disable iff (rst) qfull);
endmodule
`default_nettype wire

// >>> can_mbx_pkg.sv
// constants, types and register map of the mailbox block
package can_mbx_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_MB  = 32;
  localparam int MBW     = 5;
  localparam int QDEPTH  = 4;
  localparam int QPW     = 2;
  localparam int QCW     = 3;
  localparam int MEM_AW  = 7;
  localparam int AW      = 12;
  localparam int IRQ_W   = 4;
  localparam int CH_MAX  = 2;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [AW-1:0] A_CTRL  = 12'h000;
  localparam logic [AW-1:0] A_STAT  = 12'h004;
  localparam logic [AW-1:0] A_ISTAT = 12'h008;
  localparam logic [AW-1:0] A_IMASK = 12'h00C;
  localparam logic [AW-1:0] A_SENT  = 12'h010;
  localparam logic [AW-1:0] A_LOST  = 12'h014;
  localparam logic [AW-1:0] A_RXNEW = 12'h018;
  localparam logic [AW-1:0] A_QPUSH = 12'h01C;
  localparam logic [AW-1:0] A_KIND  = 12'h020;
  localparam logic [AW-1:0] A_SREQ  = 12'h024;
  localparam logic [AW-1:0] A_RXEN  = 12'h028;
  localparam logic [AW-1:0] A_WIN   = 12'h100;
  localparam logic [AW-1:0] A_WEND  = 12'h2FF;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_QEN_BIT  = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int IRQ_SENT  = 0;
  localparam int IRQ_RX    = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_LOST  = 3;
  localparam int RTR_BIT   = 29;
  localparam int IDE_BIT   = 30;
  localparam logic [1:0] W_ID  = 2'h0;
  localparam logic [1:0] W_DLO = 2'h1;
  localparam logic [1:0] W_DHI = 2'h2;
  localparam logic [1:0] W_DLC = 2'h3;
  localparam logic [QCW-1:0] FETCH_WORDS = 3'h4;
  localparam logic MB_KIND_NORMAL = 1'b0;
  localparam logic MB_KIND_FIFO   = 1'b1;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_OFFER, TX_SENDING} tx_st_e;
  typedef enum logic [0:0] {RX_IDLE, RX_STORE} rx_st_e;
endpackage

// >>> mbx_mem_if.sv
// port bundle between the control logic and the mailbox memory
`timescale 1ns/1ps
`default_nettype none
interface mbx_mem_if;
  import can_mbx_pkg::*;
  logic              we;
  logic [MEM_AW-1:0] waddr;
  logic [31:0]       wdata;
  logic [MEM_AW-1:0] raddr;
  logic [31:0]       rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> mbx_mem.sv
// mailbox contents memory, registered read
`timescale 1ns/1ps
`default_nettype none
module mbx_mem (
  input wire logic mclk,
  mbx_mem_if.mem   m
);
  import can_mbx_pkg::*;
  logic [31:0] ram [0:(1<<MEM_AW)-1];
  logic [31:0] q_r;
  // no reset: contents are only meaningful after software loads them
  always_ff @(posedge mclk) begin
    if (m.we) begin
      ram[m.waddr] <= m.wdata;
    end
    q_r <= ram[m.raddr];
  end
  assign m.rdata = q_r;
endmodule
`default_nettype wire

// >>> tx_queue.sv
// four-deep queue of mailbox numbers awaiting transmission
`timescale 1ns/1ps
`default_nettype none
module tx_queue (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      push,
  input  wire logic [can_mbx_pkg::MBW-1:0] push_idx,
  input  wire logic                      pop,
  input  wire logic                      flush,
  output wire logic [can_mbx_pkg::MBW-1:0] head,
  output wire logic                      full,
  output wire logic                      empty,
  output wire logic [can_mbx_pkg::QCW-1:0] count
);
  import can_mbx_pkg::*;
  typedef struct packed {
    logic [QDEPTH-1:0][MBW-1:0] slot;
    logic [QPW-1:0]             wp;
    logic [QPW-1:0]             rp;
    logic [QCW-1:0]             cnt;
  } q_s;
  q_s st_r, st_nxt;
  logic do_push, do_pop;
  always_comb begin
    st_nxt  = st_r;
    do_push = push && (st_r.cnt != QCW'(QDEPTH));
    do_pop  = pop && (st_r.cnt != '0);
    if (do_push) begin
      st_nxt.slot[st_r.wp] = push_idx;
      st_nxt.wp = st_r.wp + 2'h1;
    end
    if (do_pop) begin
      st_nxt.rp = st_r.rp + 2'h1;
    end
    st_nxt.cnt = st_r.cnt + QCW'(do_push) - QCW'(do_pop);
    if (flush) begin
      st_nxt.rp  = st_nxt.wp;
      st_nxt.cnt = '0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign head  = st_r.slot[st_r.rp];
  assign full  = (st_r.cnt == QCW'(QDEPTH));
  assign empty = (st_r.cnt == '0);
  assign count = st_r.cnt;
endmodule
`default_nettype wire

// >>> can_bus_node.sv
// protocol engine model: starts, then finishes, every frame offered while stall is low
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tx_req,
  input  wire logic stall,
  output var logic  tx_start,
  output var logic  tx_done
);
  logic [3:0] cnt;
  // stall before start leaves room for a cancel
  always_ff @(posedge mclk) begin
    tx_start <= 1'b0;
    tx_done  <= 1'b0;
    if (rst || !tx_req)
      cnt <= 4'h0;
    else if (!stall && cnt != 4'hF) begin
      cnt      <= cnt + 4'h1;
      tx_start <= cnt == 4'h2;
      tx_done  <= cnt == 4'h5;
    end
  end
endmodule
`default_nettype wire

// >>> can_mailbox_test.sv
// self-checking bench of the mailbox block
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_test;
  import can_mbx_pkg::*;
  logic          mclk = 0, rst = 1, wr_en = 0, rd_en = 0, stall = 0;
  logic          rx_valid = 0, rx_ide = 0, rx_rtr = 0;
  logic [AW-1:0] addr = '0;
  logic [31:0]   wdata = '0, rd_data, v, w0, d0, d1;
  logic [28:0]   tx_id, rx_id = '0;
  logic [63:0]   tx_data, rx_data = '0;
  logic [3:0]    tx_dlc, rx_dlc = '0;
  logic          irq, tx_req, tx_ide, tx_rtr, tx_start, tx_done;
  int            n_errors = 0, n_tests = 0, cyc = 0, qn, mb, seed = 32'hcc17;
  can_mailbox can_mailbox_inst (.*);
  can_bus_node can_bus_node_inst (.*);
  initial forever #12.5 mclk = ~mclk;
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [AW-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  // bounded wait, then compare the settled level
  task wait_tx(input logic lvl);
    for (int i = 0; i < 60 && tx_req !== lvl; i++) @(posedge mclk);
    #1 chk(tx_req, lvl);
  endtask
  function logic [AW-1:0] wa(int m, int w);
    return A_WIN + AW'(m * 16 + w * 4);
  endfunction
  function logic [31:0] stat_exp(int n, logic h);
    return {23'h0, h, 3'h0, 3'(n), n == 0, n == QDEPTH};
  endfunction
  task give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(A_CTRL); chk(v, CTRL_RST);
    rd(A_STAT); chk(v, stat_exp(0, 1'b1));
    rd(12'h0FC); chk(v, 32'h0);
    $display("reset test done");
    wr(A_CTRL, 32'h0);
    for (int k = 0; k < 2; k++) begin
      mb = k ? 31 : 7; // edge mailbox too
      w0 = k ? {3'h3, 29'($random(seed))} : 32'h1;
      d0 = $random(seed);
      d1 = $random(seed);
      wr(A_IMASK, 32'h0);
      wr(wa(mb, 0), w0); wr(wa(mb, 1), d0); wr(wa(mb, 2), d1);
      wr(wa(mb, 3), k ? 32'h8 : 32'h2);
      wr(A_IMASK, 32'h5);
      repeat (2) begin
        wr(A_SREQ, 32'h1 << mb);
        wait_tx(1'b1);
        chk(tx_id, w0[28:0]);
        chk({tx_ide, tx_rtr}, w0[30:29]);
        chk(tx_dlc, k ? 4'h8 : 4'h2);
        chk(tx_data, {d1, d0});
        wait_tx(1'b0);
        rd(A_SENT); chk(v, 32'h1 << mb);
        rd(A_SREQ); chk({irq, v}, {1'b1, 32'h0});
        wr(A_ISTAT, 32'h1);
        wr(A_SENT, 32'hFFFFFFFF);
        #1 chk(irq, 1'b0);
      end
    end
    $display("send test done");
    stall <= 1'b1;
    wr(A_SREQ, 32'h80);
    wait_tx(1'b1);
    wr(A_SREQ, 32'h0);
    wait_tx(1'b0);
    rd(A_ISTAT); chk({irq, v}, {1'b1, 32'h4});
    stall <= 1'b0;
    wr(A_ISTAT, 32'hF);
    $display("abort test done");
    wr(A_CTRL, 32'h1); wr(A_KIND, 32'h3E); wr(A_CTRL, 32'h3);
    qn = 0;
    for (int m = 0; m < 6; m++) begin
      wr(A_QPUSH, m);
      if (m > 0 && qn < QDEPTH) qn++;
    end
    rd(A_STAT); chk(v, stat_exp(qn, 1'b1));
    wr(A_CTRL, 32'h1);
    rd(A_STAT); chk(v, stat_exp(0, 1'b1));
    for (int w = 0; w < 4; w++) wr(wa(2, w), w ? w : 32'h123);
    wr(A_CTRL, 32'h3); wr(A_QPUSH, 32'h2); wr(A_CTRL, 32'h2);
    wait_tx(1'b1);
    chk(tx_id, 29'h123);
    chk(tx_dlc, 4'h3);
    wait_tx(1'b0);
    rd(A_SENT); chk(v, 32'h4);
    $display("queue test done");
    wr(A_CTRL, 32'h1); wr(wa(8, 0), 32'h10); wr(A_RXEN, 32'h100);
    wr(A_CTRL, 32'h0);
    // third frame lands on an unread mailbox: overwrite must be flagged
    for (int k = 0; k < 3; k++) begin
      d0 = $random(seed);
      d1 = $random(seed);
      @(posedge mclk);
      rx_id <= k ? 29'h10 : 29'h11;
      rx_data <= {d1, d0};
      rx_dlc <= 4'h3;
      rx_valid <= 1'b1;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_data <= ~{d1, d0};
      repeat (8) @(posedge mclk);
      rd(A_RXNEW); chk(v, k ? 32'h100 : 32'h0);
    end
    rd(A_LOST); chk(v, 32'h100);
    rd(A_ISTAT); chk(v, 32'hB);
    rd(wa(8, 1)); chk(v, d0);
    rd(wa(8, 3)); chk(v[3:0], 4'h3);
    $display("receive test done");
    give_verdict;
  end
endmodule
`default_nettype wire
